// ==== tmh_pkg.sv ====
// shared constants, types and states of the test mode message handler
package tmh_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam logic [3:0] PD_TEST = 4'hf;
  localparam logic [3:0] SKIP_NONE = 4'h0;
  localparam int unsigned SKIP_MSB = 7;
  localparam int unsigned SKIP_LSB = 4;
  localparam int unsigned PD_MSB = 3;
  localparam logic [3:0] TYPE_CELL_0 = 4'h0;
  localparam logic [3:0] TYPE_CELL_1 = 4'h1;
  localparam logic [3:0] TYPE_CELL_2 = 4'h2;
  localparam logic [3:0] TYPE_OTHER_RAT = 4'h4;
  localparam logic [7:0] MT_LOOP_CLOSE = 8'h00;
  localparam logic [7:0] MT_LOOP_CLOSE_ACK = 8'h01;
  localparam logic [7:0] MT_LOOP_OPEN = 8'h06;
  localparam logic [7:0] MT_MAINT_DEACT = 8'h10;
  localparam logic [7:0] MT_MS_LOOP_CLOSE = 8'h20;
  localparam logic [7:0] MT_MS_LOOP_ACK = 8'h21;
  localparam logic [7:0] MT_MAINT_ACT = 8'h0c;
  localparam logic [7:0] MT_MAINT_ACT_ACK = 8'h0d;
  localparam logic [7:0] MT_AUDIO_SELECT = 8'h14;
  localparam logic [3:0] IEI_ACK = 4'h8;
  localparam logic [3:0] IE_ACK_VAL = 4'h1;
  localparam int unsigned SUB_X_BIT = 0;
  localparam int unsigned SUB_LOOP_LSB = 1;
  localparam int unsigned LT_CHC_LSB = 0;
  localparam int unsigned LT_MECH_LSB = 2;
  localparam int unsigned LT_TN_LSB = 5;
  localparam logic [1:0] CHC_TYPE_G = 2'h0;
  localparam logic [1:0] CHC_TYPE_H = 2'h1;
  localparam logic [2:0] MECH_1 = 3'h0;
  localparam logic [2:0] MECH_2 = 3'h1;
  localparam logic [2:0] DEV_NORMAL = 3'h0;
  localparam logic [2:0] DEV_DL_DECODER = 3'h1;
  localparam logic [2:0] DEV_UL_ENCODER = 3'h2;
  localparam logic [2:0] DEV_ACOUSTIC = 3'h4;
  localparam logic [2:0] HOQAM_DATA_BLOCKS = 3'h4;
  localparam logic [2:0] HOQAM_RETX_BLOCKS = 3'h5;
  localparam logic [2:0] PLAIN_RETX_BLOCKS = 3'h1;
  localparam int unsigned FIFO_WIDTH = 9;
  localparam int unsigned FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    TMH_LOOP_A = 3'h0,
    TMH_LOOP_B = 3'h1,
    TMH_LOOP_C = 3'h2,
    TMH_LOOP_D = 3'h3,
    TMH_LOOP_E = 3'h4,
    TMH_LOOP_F = 3'h5,
    TMH_LOOP_I = 3'h6,
    TMH_LOOP_BAD = 3'h7
  } tmh_loop_type;

  typedef enum logic [2:0] {
    TMH_S_RX = 3'h0,
    TMH_S_EXEC = 3'h1,
    TMH_S_HDR = 3'h2,
    TMH_S_TYPE = 3'h3,
    TMH_S_ARG = 3'h4
  } tmh_state_type;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } tmh_beat_type;

  typedef struct packed {
    logic [1:0] channel_coding_field;
    logic [2:0] mech;
    logic [2:0] tn;
  } tmh_msloop_type;
endpackage : tmh_pkg

// ==== tmh_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
module tmh_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count_r < (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (rst)
    count_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : tmh_fifo

// ==== tmh_handler.sv ====
// test mode message decoder, maintenance and audio test sequencer
//
// Contract
// (RL1) 16qam up, 32qam down: four data blocks plus dummy, resent over five blocks.
// (RL2) maintenance interface active only with test sim; power-on, insertion or command.
// (RL3) one xon message once the maintenance interface can take frames.
// (RL4) deactivate on power-off, sim removal or command; never send stop-flow.
// (RL5) every maintenance activate command gets an activate acknowledgement.
// (RL6) maintenance deactivate command is not acknowledged.
// (RL7) audio test starts by select message or control signal, per declared method.
// (RL8) select message needs an established dedicated channel first.
// (RL9) while audio test active, each new selection replaces the previous one.
// (RL10) messages with nonzero skip indicator are ignored.
// (RL11) test discriminator 1111; type series 0000,0001,0010 cellular, 0100 other.
// (RL12) commands only arrive; loop close 00000000, loop open 00000110.
// (RL13) device sends loop close ack 00000001 and multi-slot ack only; the code also sends the activate ack 00001101.
// (RL14) sub-channel bit 1 picks half-rate sub-channel; bits 8,7 spare.
// (RL15) sub-channel bits 6..2 select loop a..f or i, x bits ignored.
// (RL16) loop open may carry acknowledge element 1000 / 0001.
// (RL17) channel coding 00 type g, 01 type h, others reserved.
// (RL18) loop mechanism 000 mechanism 1, 001 mechanism 2, others reserved.
// (RL19) timeslot 0..7 used only with mechanism 1.
// (RL20) multi-slot result echoes coding and mechanism, bit 1 is error.
// (RL21) tested device 000,001,010,100 valid; other codes reserved.
// (RL22) maintenance deactivate recognised by type 00010000.
// (RL23) reserved multi-slot codes leave loop open and report error.
module tmh_handler (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic power_on,
  input wire logic test_sim_present,
  input wire logic maint_frame_ready,
  output logic maint_active,
  output logic maint_xon,
  output logic maint_stop_flow,
  input wire logic audio_by_message,
  input wire logic dedicated_channel,
  input wire logic audio_ctrl_valid,
  input wire logic [2:0] audio_ctrl_sel,
  output logic [2:0] audio_tested_device,
  output logic audio_test_active,
  output logic loop_closed,
  output tmh_pkg::tmh_loop_type loop_select,
  output logic loop_subchannel,
  output logic msloop_closed,
  output tmh_pkg::tmh_msloop_type msloop_cfg,
  output logic open_ack_requested,
  input wire logic ul_16qam,
  input wire logic dl_32qam,
  input wire logic block_strobe,
  input wire logic block_dummy,
  output logic [2:0] retx_blocks,
  output logic retx_group_done
);
  function automatic tmh_pkg::tmh_loop_type decode_loop(input logic [4:0] cbazy);
    casez (cbazy)
      5'b00000: decode_loop = tmh_pkg::TMH_LOOP_A;
      5'b00001: decode_loop = tmh_pkg::TMH_LOOP_B;
      5'b0001?: decode_loop = tmh_pkg::TMH_LOOP_C;
      5'b001??: decode_loop = tmh_pkg::TMH_LOOP_D;
      5'b010??: decode_loop = tmh_pkg::TMH_LOOP_E;
      5'b011??: decode_loop = tmh_pkg::TMH_LOOP_F;
      5'b111??: decode_loop = tmh_pkg::TMH_LOOP_I;
      default: decode_loop = tmh_pkg::TMH_LOOP_BAD;
    endcase
  endfunction : decode_loop

  function automatic logic device_code_ok(input logic [2:0] dev);
    device_code_ok = (dev == tmh_pkg::DEV_NORMAL) || (dev == tmh_pkg::DEV_DL_DECODER) ||
                     (dev == tmh_pkg::DEV_UL_ENCODER) || (dev == tmh_pkg::DEV_ACOUSTIC);
  endfunction : device_code_ok

  // two-flop synchronisers for the pins
  logic [6:0] pin_a_r;
  logic [6:0] pin_b_r;
  logic [6:0] pin_c_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_a_r <= 7'h00;
      pin_b_r <= 7'h00;
      pin_c_r <= 7'h00;
    end else begin
      pin_a_r <= {power_on, test_sim_present, maint_frame_ready, audio_ctrl_valid,
                  audio_ctrl_sel};
      pin_b_r <= pin_a_r;
      pin_c_r <= pin_b_r;
    end
  end
  logic pwr_s;
  logic sim_s;
  logic frame_rdy_s;
  logic actl_s;
  logic [2:0] asel_s;
  assign {pwr_s, sim_s, frame_rdy_s, actl_s, asel_s} = pin_b_r;
  logic pwr_rise;
  logic pwr_fall;
  logic sim_rise;
  logic sim_fall;
  logic actl_rise;
  assign pwr_rise = pwr_s && !pin_c_r[6];
  assign pwr_fall = !pwr_s && pin_c_r[6];
  assign sim_rise = sim_s && !pin_c_r[5];
  assign sim_fall = !sim_s && pin_c_r[5];
  assign actl_rise = actl_s && !pin_c_r[3];

  // message capture
  tmh_pkg::tmh_state_type state_r;
  logic [1:0] idx_r;
  logic [7:0] hdr_r;
  logic [7:0] type_r;
  logic [7:0] arg_r;
  logic arg_seen_r;
  logic take;
  assign take = rx_valid && rx_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_r <= 2'h0;
      hdr_r <= 8'h00;
      type_r <= 8'h00;
      arg_r <= 8'h00;
      arg_seen_r <= 1'b0;
    end else if (take) begin
      idx_r <= rx_last ? 2'h0 : ((idx_r == 2'h3) ? idx_r : idx_r + 2'h1);
      case (idx_r)
        2'h0: begin
          hdr_r <= rx_data;
          arg_seen_r <= 1'b0;
        end
        2'h1: type_r <= rx_data;
        2'h2: begin
          arg_r <= rx_data;
          arg_seen_r <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // header screening and command decode
  logic hdr_ok;
  logic cell_series;
  assign hdr_ok = (hdr_r[tmh_pkg::SKIP_MSB:tmh_pkg::SKIP_LSB] == tmh_pkg::SKIP_NONE) && // [RL10]
                  (hdr_r[tmh_pkg::PD_MSB:0] == tmh_pkg::PD_TEST); // [RL11]
  assign cell_series = (type_r[7:4] == tmh_pkg::TYPE_CELL_0) || // [RL11]
                       (type_r[7:4] == tmh_pkg::TYPE_CELL_1) ||
                       (type_r[7:4] == tmh_pkg::TYPE_CELL_2);
  logic exec_ok;
  assign exec_ok = (state_r == tmh_pkg::TMH_S_EXEC) && hdr_ok && cell_series;
  logic is_close;
  logic is_open;
  logic is_ms_close;
  logic is_act;
  logic is_deact;
  logic is_audio;
  assign is_close = exec_ok && (type_r == tmh_pkg::MT_LOOP_CLOSE) && arg_seen_r; // [RL12]
  assign is_open = exec_ok && (type_r == tmh_pkg::MT_LOOP_OPEN); // [RL12]
  assign is_ms_close = exec_ok && (type_r == tmh_pkg::MT_MS_LOOP_CLOSE) && arg_seen_r;
  assign is_act = exec_ok && (type_r == tmh_pkg::MT_MAINT_ACT);
  assign is_deact = exec_ok && (type_r == tmh_pkg::MT_MAINT_DEACT); // [RL22]
  assign is_audio = exec_ok && (type_r == tmh_pkg::MT_AUDIO_SELECT) && arg_seen_r;

  tmh_pkg::tmh_loop_type sub_loop;
  assign sub_loop = decode_loop(arg_r[5:tmh_pkg::SUB_LOOP_LSB]); // [RL15]
  tmh_pkg::tmh_msloop_type lt;
  logic lt_bad;
  assign lt.channel_coding_field = arg_r[tmh_pkg::LT_CHC_LSB +: 2];
  assign lt.mech = arg_r[tmh_pkg::LT_MECH_LSB +: 3];
  assign lt.tn = (arg_r[tmh_pkg::LT_MECH_LSB +: 3] == tmh_pkg::MECH_1) ?
                 arg_r[tmh_pkg::LT_TN_LSB +: 3] : 3'h0; // [RL19]
  assign lt_bad = !((lt.channel_coding_field == tmh_pkg::CHC_TYPE_G) || (lt.channel_coding_field == tmh_pkg::CHC_TYPE_H)) || // [RL17]
                  !((lt.mech == tmh_pkg::MECH_1) || (lt.mech == tmh_pkg::MECH_2)); // [RL18]

  // reply sequencer into the fifo
  logic [7:0] rep_type_r;
  logic [7:0] rep_arg_r;
  logic rep_has_arg_r;
  tmh_pkg::tmh_beat_type push_beat;
  logic push_valid;
  logic push_ready;
  always_comb begin
    push_valid = 1'b0;
    push_beat.data = 8'h00;
    push_beat.last = 1'b0;
    case (state_r)
      tmh_pkg::TMH_S_HDR: begin
        push_valid = 1'b1;
        push_beat.data = {tmh_pkg::SKIP_NONE, tmh_pkg::PD_TEST};
      end
      tmh_pkg::TMH_S_TYPE: begin
        push_valid = 1'b1;
        push_beat.data = rep_type_r;
        push_beat.last = !rep_has_arg_r;
      end
      tmh_pkg::TMH_S_ARG: begin
        push_valid = 1'b1;
        push_beat.data = rep_arg_r;
        push_beat.last = 1'b1;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= tmh_pkg::TMH_S_RX;
      rx_ready <= 1'b1;
      rep_type_r <= 8'h00;
      rep_arg_r <= 8'h00;
      rep_has_arg_r <= 1'b0;
    end else begin
      case (state_r)
        tmh_pkg::TMH_S_RX: begin
          if (take && rx_last) begin
            state_r <= tmh_pkg::TMH_S_EXEC;
            rx_ready <= 1'b0;
          end
        end
        tmh_pkg::TMH_S_EXEC: begin
          if (is_close) begin
            rep_type_r <= tmh_pkg::MT_LOOP_CLOSE_ACK; // [RL13]
            rep_has_arg_r <= 1'b0;
            state_r <= tmh_pkg::TMH_S_HDR;
          end else if (is_ms_close) begin
            rep_type_r <= tmh_pkg::MT_MS_LOOP_ACK; // [RL13]
            rep_arg_r <= {2'h0, lt.channel_coding_field, lt.mech, lt_bad}; // [RL20] [RL23]
            rep_has_arg_r <= 1'b1;
            state_r <= tmh_pkg::TMH_S_HDR;
          end else if (is_act) begin
            rep_type_r <= tmh_pkg::MT_MAINT_ACT_ACK; // [RL5]
            rep_has_arg_r <= 1'b0;
            state_r <= tmh_pkg::TMH_S_HDR;
          end else begin
            // deactivate and everything else end silently
            state_r <= tmh_pkg::TMH_S_RX; // [RL6]
            rx_ready <= 1'b1;
          end
        end
        tmh_pkg::TMH_S_HDR: begin
          if (push_ready) begin
            state_r <= tmh_pkg::TMH_S_TYPE;
          end
        end
        tmh_pkg::TMH_S_TYPE: begin
          if (push_ready) begin
            if (rep_has_arg_r) begin
              state_r <= tmh_pkg::TMH_S_ARG;
            end else begin
              state_r <= tmh_pkg::TMH_S_RX;
              rx_ready <= 1'b1;
            end
          end
        end
        tmh_pkg::TMH_S_ARG: begin
          if (push_ready) begin
            state_r <= tmh_pkg::TMH_S_RX;
            rx_ready <= 1'b1;
          end
        end
        default: begin
          state_r <= tmh_pkg::TMH_S_RX;
          rx_ready <= 1'b1;
        end
      endcase
    end
  end

  tmh_pkg::tmh_beat_type pop_beat;
  tmh_fifo #(
    .WIDTH(tmh_pkg::FIFO_WIDTH),
    .DEPTH(tmh_pkg::FIFO_DEPTH)
  ) u_reply_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_beat),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(pop_beat)
  );
  assign tx_data = pop_beat.data;
  assign tx_last = pop_beat.last;

  // single-slot loop state
  localparam logic IE_ACK_BIT = tmh_pkg::IE_ACK_VAL[0];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_closed <= 1'b0;
      loop_select <= tmh_pkg::TMH_LOOP_A;
      loop_subchannel <= 1'b0;
      open_ack_requested <= 1'b0;
    end else begin
      open_ack_requested <= 1'b0;
      if (is_close) begin
        loop_closed <= (sub_loop != tmh_pkg::TMH_LOOP_BAD);
        loop_select <= sub_loop; // [RL15]
        loop_subchannel <= arg_r[tmh_pkg::SUB_X_BIT]; // [RL14]
      end else if (is_open) begin
        loop_closed <= 1'b0;
        open_ack_requested <= arg_seen_r && (arg_r[7:4] == tmh_pkg::IEI_ACK) &&
                              (arg_r[0] == IE_ACK_BIT); // [RL16]
      end
    end
  end

  // multi-slot loop state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msloop_closed <= 1'b0;
      msloop_cfg <= '0;
    end else if (is_ms_close) begin
      msloop_closed <= !lt_bad; // [RL23]
      if (!lt_bad) begin
        msloop_cfg <= lt; // [RL19]
      end
    end else if (is_open) begin
      msloop_closed <= 1'b0;
    end
  end

  // maintenance interface sequencing
  logic xon_due_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      maint_active <= 1'b0;
      xon_due_r <= 1'b0;
      maint_xon <= 1'b0;
      maint_stop_flow <= 1'b0;
    end else begin
      maint_xon <= 1'b0;
      maint_stop_flow <= 1'b0; // [RL4]
      if (!sim_s || pwr_fall || sim_fall || is_deact) begin
        maint_active <= 1'b0; // [RL4] [RL6]
        xon_due_r <= 1'b0;
      end else if (!maint_active && pwr_s && (pwr_rise || sim_rise || is_act)) begin
        maint_active <= 1'b1; // [RL2]
        xon_due_r <= 1'b1;
      end else if (xon_due_r && frame_rdy_s) begin
        maint_xon <= 1'b1; // [RL3]
        xon_due_r <= 1'b0;
      end
    end
  end

  // audio test interface selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      audio_tested_device <= tmh_pkg::DEV_NORMAL;
      audio_test_active <= 1'b0;
    end else if (audio_by_message && dedicated_channel && is_audio &&
                 device_code_ok(arg_r[2:0])) begin // [RL7] [RL8] [RL21]
      audio_tested_device <= arg_r[2:0]; // [RL9]
      audio_test_active <= (arg_r[2:0] != tmh_pkg::DEV_NORMAL);
    end else if (!audio_by_message && actl_rise && device_code_ok(asel_s)) begin // [RL7]
      audio_tested_device <= asel_s; // [RL9]
      audio_test_active <= (asel_s != tmh_pkg::DEV_NORMAL);
    end
  end

  // high-order modulation retransmission grouping
  logic [2:0] data_cnt_r;
  logic hoqam;
  assign hoqam = ul_16qam && dl_32qam;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_cnt_r <= 3'h0;
      retx_blocks <= tmh_pkg::PLAIN_RETX_BLOCKS;
      retx_group_done <= 1'b0;
    end else begin
      retx_blocks <= hoqam ? tmh_pkg::HOQAM_RETX_BLOCKS : tmh_pkg::PLAIN_RETX_BLOCKS; // [RL1]
      retx_group_done <= 1'b0;
      if (!hoqam) begin
        data_cnt_r <= 3'h0;
      end else if (block_strobe) begin
        if (!block_dummy) begin
          data_cnt_r <= (data_cnt_r == tmh_pkg::HOQAM_DATA_BLOCKS) ? data_cnt_r :
                        data_cnt_r + 3'h1;
        end else begin
          retx_group_done <= (data_cnt_r == tmh_pkg::HOQAM_DATA_BLOCKS); // [RL1]
          data_cnt_r <= 3'h0;
        end
      end
    end
  end

  a_deact_silent: assert property (@(posedge clk) disable iff (rst)
    is_deact |=> state_r == tmh_pkg::TMH_S_RX) else $error("deactivate produced a reply"); // [RL6]
  a_act_acked: assert property (@(posedge clk) disable iff (rst)
    is_act |=> rep_type_r == tmh_pkg::MT_MAINT_ACT_ACK && state_r == tmh_pkg::TMH_S_HDR)
    else $error("activate not acknowledged"); // [RL5]
  a_skip_ignored: assert property (@(posedge clk) disable iff (rst)
    hdr_r[7:4] != 4'h0 |-> !exec_ok) else $error("skip indicator not honoured"); // [RL10]
  a_sim_needed: assert property (@(posedge clk) disable iff (rst)
    !sim_s |=> !maint_active) else $error("maintenance active without sim"); // [RL2]
  a_no_stop_flow: assert property (@(posedge clk) disable iff (rst)
    $fell(maint_active) |-> ##[0:2] !maint_stop_flow) else $error("stop flow sent"); // [RL4]
  a_xon_once: assert property (@(posedge clk) disable iff (rst)
    maint_xon |=> !maint_xon && !xon_due_r) else $error("xon repeated"); // [RL3]
  a_ms_reserved: assert property (@(posedge clk) disable iff (rst)
    is_ms_close && lt_bad |=> !msloop_closed && rep_arg_r[0]) else $error("reserved code closed"); // [RL23]
  a_close_ack: assert property (@(posedge clk) disable iff (rst)
    is_close |=> rep_type_r == tmh_pkg::MT_LOOP_CLOSE_ACK && push_beat.data == 8'h0f)
    else $error("loop close ack malformed"); // [RL13]
  a_hoqam_span: assert property (@(posedge clk) disable iff (rst)
    hoqam ##1 hoqam |-> retx_blocks == 3'h5) else $error("retransmit span wrong"); // [RL1]
  a_audio_kept: assert property (@(posedge clk) disable iff (rst)
    is_audio && !device_code_ok(arg_r[2:0]) |=> $stable(audio_tested_device))
    else $error("reserved tested device accepted"); // [RL21]
endmodule : tmh_handler

// ==== tmh_tss.sv ====
// test system model: sends command bytes, drains replies with stalls
module tmh_tss (
  input wire logic clk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold_off = 1'b0;
  initial {rx_valid, rx_data, rx_last, tx_ready} = 11'h000;
  // random reply stalls, full stop while hold_off
  always @(negedge clk) tx_ready <= !hold_off && $urandom_range(3) != 0;
  // commands only ever flow towards the device
  task automatic send(input logic [7:0] m[$]);
    foreach (m[i]) begin
      @(negedge clk);
      {rx_valid, rx_data, rx_last} = {1'b1, m[i], i == m.size() - 1};
      do @(posedge clk); while (rx_ready !== 1'b1);
    end
    @(negedge clk);
    {rx_valid, rx_data, rx_last} = {1'b0, ~rx_data, 1'b0};
  endtask : send
endmodule : tmh_tss

// ==== testbench.sv ====
// self-checking bench for the test mode message handler
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst, rx_valid, rx_ready, rx_last, tx_valid, tx_ready, tx_last, power_on;
  logic test_sim_present, maint_frame_ready, maint_active, maint_xon, maint_stop_flow;
  logic audio_by_message, dedicated_channel, audio_ctrl_valid, audio_test_active;
  logic loop_closed, loop_subchannel, msloop_closed, open_ack_requested, ul_16qam;
  logic dl_32qam, block_strobe, block_dummy, retx_group_done;
  logic [7:0] rx_data, tx_data;
  logic [2:0] audio_ctrl_sel, audio_tested_device, retx_blocks;
  tmh_pkg::tmh_loop_type loop_select;
  tmh_pkg::tmh_msloop_type msloop_cfg;
  logic [8:0] exp_q[$];
  int bad_count = 0, n_checks = 0, xon_n = 0, oack_n = 0, grp_n = 0, stop_n = 0;
  localparam logic [4:0] LP [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h0c, 5'h1c, 5'h10};
  localparam logic [4:0] DC [8] = '{5'h00, 5'h00, 5'h01, 5'h03, 5'h03, 5'h03, 5'h03, 5'h00};
  localparam logic [2:0] AC [7] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h0, 3'h4, 3'h2};
  always #2 clk = ~clk;
  tmh_handler uut (.clk, .rst, .rx_valid, .rx_ready, .rx_data, .rx_last, .tx_valid, .tx_ready,
    .tx_data, .tx_last, .power_on, .test_sim_present, .maint_frame_ready, .maint_active,
    .maint_xon, .maint_stop_flow, .audio_by_message, .dedicated_channel, .audio_ctrl_valid,
    .audio_ctrl_sel, .audio_tested_device, .audio_test_active, .loop_closed, .loop_select,
    .loop_subchannel, .msloop_closed, .msloop_cfg, .open_ack_requested, .ul_16qam, .dl_32qam,
    .block_strobe, .block_dummy, .retx_blocks, .retx_group_done);
  tmh_tss tss (.clk, .rx_ready, .rx_valid, .rx_data, .rx_last, .tx_ready);
  task automatic chk(input logic [8:0] seen, input logic [8:0] want, input string what);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH %0t %s: %h vs %h", $time, what, seen, want);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic note(input logic [7:0] mt, input logic [8:0] res);
    exp_q.push_back(9'h00f);
    exp_q.push_back({~res[8], mt});
    if (res[8]) exp_q.push_back({1'b1, res[7:0]});
  endtask : note
  task automatic cmd(input logic [7:0] hdr, input logic [7:0] mt, input logic [8:0] arg);
    logic [7:0] q[$];
    int n;
    q = {hdr, mt};
    if (arg[8]) q.push_back(arg[7:0]);
    tss.send(q);
    n = 0;
    idle(2);
    while (rx_ready !== 1'b1 && n < 200) begin
      idle(1);
      n++;
    end
    chk(rx_ready, 1'b1, "ready back");
    idle(1);
  endtask : cmd
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 500) begin
      idle(1);
      n++;
    end
    chk(9'(exp_q.size()), 9'h000, "drain");
  endtask : drain
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      chk({tx_last, tx_data}, (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff, "reply");
    end
    if (maint_xon === 1'b1) xon_n++;
    if (open_ack_requested === 1'b1) oack_n++;
    if (retx_group_done === 1'b1) grp_n++;
    if (maint_stop_flow !== 1'b0 && rst === 1'b0) stop_n++;
  end
  initial begin
    logic [31:0] r;
    logic [7:0] prev;
    logic [2:0] dev, mech;
    logic [1:0] channel_coding_field;
    {rst, power_on, test_sim_present, maint_frame_ready, audio_by_message} = 5'h19;
    {dedicated_channel, audio_ctrl_valid, audio_ctrl_sel, ul_16qam, dl_32qam} = 7'h40;
    {block_strobe, block_dummy} = 2'h0;
    r = $urandom(60);
    idle(12);
    rst = 1'b0;
    idle(4);
    chk(maint_active, 1'b0, "no sim");
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      note(8'h01, 9'h000);
      cmd(8'h0f, 8'h00, {3'h4, LP[i] | (r[4:0] & DC[i]), r[5]});
      chk(9'(loop_select), 9'(i), "loop");
      chk(loop_subchannel, r[5], "subch");
      chk(loop_closed, i < 7, "closed");
    end
    note(8'h01, 9'h000);
    cmd(8'h0f, 8'h00, 9'h100);
    for (int i = 0; i < 3; i++) begin
      cmd((i == 0) ? 8'h1f : (i == 1) ? 8'h0e : 8'h0f, (i == 2) ? 8'h46 : 8'h06, 9'h000);
      chk(loop_closed, 1'b1, "ignored");
    end
    cmd(8'h0f, 8'h06, 9'h181);
    chk(loop_closed, 1'b0, "opened");
    cmd(8'h0f, 8'h06, 9'h000);
    chk(9'(oack_n), 9'h001, "open ack");
    drain();
    tss.hold_off = 1'b1;
    repeat (5) begin
      note(8'h01, 9'h000);
      tss.send('{8'h0f, 8'h00, 8'h04});
    end
    idle(10);
    chk(rx_ready, 1'b0, "fifo full");
    tss.hold_off = 1'b0;
    drain();
    for (int c = 0; c < 6; c++) begin
      r = $urandom;
      channel_coding_field = (c == 4) ? 2'h2 : 2'(c % 2);
      mech = (c == 5) ? 3'h3 : (c > 3) ? 3'h0 : 3'(c / 2);
      if (c == 4) cmd(8'h0f, 8'h06, 9'h000);
      if (c < 4) prev = {channel_coding_field, mech, (mech == 3'h0) ? r[2:0] : 3'h0};
      note(8'h21, {3'h4, channel_coding_field, mech, c > 3});
      cmd(8'h0f, 8'h20, {1'b1, r[2:0], mech, channel_coding_field});
      chk(msloop_cfg, prev, "ms cfg");
      chk(msloop_closed, c < 4, "ms closed");
    end
    test_sim_present = 1'b1;
    idle(8);
    chk(maint_active, 1'b1, "sim in");
    maint_frame_ready = 1'b1;
    idle(8);
    chk(9'(xon_n), 9'h001, "xon");
    cmd(8'h0f, 8'h10, 9'h000);
    chk(maint_active, 1'b0, "deact");
    for (int i = 0; i < 2; i++) begin
      note(8'h0d, 9'h000);
      cmd(8'h0f, 8'h0c, 9'h000);
      idle(8);
      chk(maint_active, 1'b1, "act cmd");
      chk(9'(xon_n), 9'h002, "one xon");
    end
    test_sim_present = 1'b0;
    idle(8);
    chk(maint_active, 1'b0, "sim out");
    test_sim_present = 1'b1;
    idle(8);
    power_on = 1'b0;
    idle(8);
    chk(maint_active, 1'b0, "power off");
    chk(9'(xon_n), 9'h003, "xon again");
    chk(9'(stop_n), 9'h000, "no stop");
    dev = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (AC[i] != 3'h3) dev = AC[i];
      if (i < 5) begin
        cmd(8'h0f, 8'h14, {6'h20, AC[i]});
      end else begin
        {audio_by_message, audio_ctrl_sel, audio_ctrl_valid} = {1'b0, AC[i], 1'b1};
        idle(6);
        audio_ctrl_valid = 1'b0;
        idle(6);
      end
      chk(audio_tested_device, dev, "audio");
      chk(audio_test_active, dev != 3'h0, "audio on");
    end
    {ul_16qam, dl_32qam} = 2'h3;
    idle(3);
    chk(retx_blocks, 3'h5, "retx");
    for (int i = 0; i < 10; i++) begin
      {block_strobe, block_dummy} = {1'b1, i % 5 == 4};
      idle(1);
      {block_strobe, block_dummy} = 2'h0;
      idle(3);
    end
    chk(9'(grp_n), 9'h002, "groups");
    ul_16qam = 1'b0;
    idle(3);
    chk(retx_blocks, 3'h1, "plain");
    drain();
    report_and_stop();
  end
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule : testbench
